// *** hdl/bbbe_exec.sv ***
`timescale 1ns/10ps
module bbbe_exec
    import bbbe_pkg::*;
#(
    parameter int ACC_W = 32
) (
    input wire logic clock,
    input wire logic rst_n,
    input wire logic ce,
    input wire logic [3:0] reg_addr,
    input wire logic [15:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    output logic [15:0] reg_rdata,
    input wire logic instr_valid,
    input wire bbbe_instr_t instr,
    output logic instr_ready,
    input wire logic [ACC_W-1:0] acc,
    input wire logic ext_pin_input,
    input wire logic [15:0] dm_rdata,
    output bbbe_dmem_t dm_req,
    output bbbe_fetch_t fetch,
    output logic [15:0] pc_out,
    output logic int_hold
);
    typedef enum logic [2:0] {
        ST_IDLE = 3'b000, ST_BR = 3'b001, ST_BT = 3'b010, ST_BMR = 3'b011, ST_BMD = 3'b100
    } bbbe_st_t;

    typedef struct packed {
        bbbe_st_t st;
        bbbe_instr_t ins;
        logic [15:0] pc;
        logic [2:0] cnt;
        logic taken;
        logic spec;
        logic pend;
        logic pend_taken;
        logic [15:0] pend_tgt;
        logic [1:0] dcnt;
        logic ov;
        logic tc;
        logic carry;
        logic temp_broadcast_mode;
        logic [15:0] temp_reg_zero;
        logic [15:0] temp_reg_one;
        logic [15:0] temp_reg_two;
        logic [15:0] block_addr_reg;
        logic [15:0] repeat_count_reg;
        logic [15:0] fetch_addr_ctr;
        logic [15:0] saved_fetch_ctr;
        logic rd_seen;
        logic [15:0] dst_q1;
        logic [15:0] dst_q2;
        logic ready;
        logic int_hold;
        logic [15:0] rdata;
        bbbe_fetch_t fetch;
        bbbe_dmem_t dm;
    } bbbe_state_t;

    bbbe_state_t q;
    bbbe_state_t d;
    logic taken_c;
    logic fire;

    // Bit position counts down from the top of the word
    function automatic logic bbbe_pick_bit(input logic [15:0] word, input logic [3:0] code);
        logic [3:0] pos;
        pos = BIT_MSB - code;
        return word[pos];
    endfunction : bbbe_pick_bit

    // Saturating delay-slot word counter
    function automatic logic [1:0] bbbe_add_words(input logic [1:0] a, input logic [1:0] b);
        logic [2:0] s;
        s = {1'b0, a} + {1'b0, b};
        return (s > 3'(DELAY_WORDS)) ? DELAY_WORDS : s[1:0];
    endfunction : bbbe_add_words

    // Condition uses the flags as they stand in the accept cycle
    bbbe_cond_eval #(
        .ACC_W(ACC_W)
    ) u_cond (
        .cond(instr.cond),
        .acc(acc),
        .carry(q.carry),
        .ov(q.ov),
        .tc(q.tc),
        .pin(ext_pin_input),
        .taken(taken_c)
    );

    assign fire = instr_valid && q.ready;
    assign reg_rdata = q.rdata;
    assign instr_ready = q.ready;
    assign dm_req = q.dm;
    assign fetch = q.fetch;
    assign pc_out = q.pc;
    assign int_hold = q.int_hold;

    // Next-state logic for the whole block
    always_comb begin
        d = q;
        d.rdata = '0;
        d.fetch.req = 1'b0;
        d.fetch.discard = 1'b0;
        d.dm.rd = 1'b0;
        d.dm.wr = 1'b0;
        d.rd_seen = q.dm.rd;
        d.dst_q2 = q.dst_q1;
        // Register port reads answer in the next cycle only
        if (reg_rd) begin
            case (reg_addr)
                REG_ST0: d.rdata[ST0_OV_BIT] = q.ov;
                REG_ST1: begin
                    d.rdata[ST1_TC_BIT] = q.tc;
                    d.rdata[ST1_C_BIT] = q.carry;
                end
                REG_PMODE: d.rdata[PMODE_TRM_BIT] = q.temp_broadcast_mode;
                REG_TEMP_REG_ZERO: d.rdata = q.temp_reg_zero;
                REG_TEMP_REG_ONE: d.rdata = q.temp_reg_one;
                REG_TEMP_REG_TWO: d.rdata = q.temp_reg_two;
                REG_BLOCK_ADDR_REG: d.rdata = q.block_addr_reg;
                REG_REPEAT_COUNT_REG: d.rdata = q.repeat_count_reg;
                REG_PC: d.rdata = q.pc;
                REG_PFC: d.rdata = q.fetch_addr_ctr;
                REG_MCS: d.rdata = q.saved_fetch_ctr;
                default: d.rdata = '0;
            endcase
        end
        // Software writes first, so hardware updates below win the same cycle
        if (reg_wr) begin
            case (reg_addr)
                REG_ST0: d.ov = reg_wdata[ST0_OV_BIT];
                REG_ST1: begin
                    d.tc = reg_wdata[ST1_TC_BIT];
                    d.carry = reg_wdata[ST1_C_BIT];
                end
                REG_PMODE: d.temp_broadcast_mode = reg_wdata[PMODE_TRM_BIT];
                REG_TEMP_REG_ZERO: begin
                    d.temp_reg_zero = reg_wdata;
                    if (!q.temp_broadcast_mode) begin
                        d.temp_reg_one = reg_wdata;
                        d.temp_reg_two = reg_wdata;
                    end
                end
                REG_TEMP_REG_ONE: d.temp_reg_one = reg_wdata;
                REG_TEMP_REG_TWO: d.temp_reg_two = reg_wdata;
                REG_BLOCK_ADDR_REG: d.block_addr_reg = reg_wdata;
                REG_REPEAT_COUNT_REG: d.repeat_count_reg = reg_wdata;
                default: d.ov = q.ov;
            endcase
        end
        // Write side of the block move follows each read by two cycles
        if (q.rd_seen && (q.st == ST_BMR || q.st == ST_BMD)) begin
            d.dm.wr = 1'b1;
            d.dm.waddr = q.dst_q2;
            d.dm.wdata = dm_rdata;
        end
        case (q.st)
            ST_IDLE: begin
                if (q.pend && q.dcnt >= DELAY_WORDS) begin
                    // Both delay-slot words have gone by
                    if (q.pend_taken) d.pc = q.pend_tgt;
                    d.pend = 1'b0;
                end else if (fire) begin
                    d.ins = instr;
                    if (q.pend) d.dcnt = bbbe_add_words(q.dcnt, instr.words);
                    case (instr.op)
                        OP_BR, OP_BRD: begin
                            d.taken = taken_c;
                            d.st = ST_BR;
                            if (instr.op == OP_BRD) begin
                                d.cnt = BRD_CYC - 3'h2;
                            end else begin
                                d.cnt = (taken_c ? BR_TAKEN_CYC : BR_FALL_CYC) - 3'h2;
                                d.fetch.req = 1'b1;
                                d.fetch.addr = q.pc + PC_STEP_BR;
                                d.spec = 1'b1;
                            end
                        end
                        OP_BITI, OP_BITR: begin
                            d.dm.rd = 1'b1;
                            d.dm.raddr = instr.dma;
                            d.st = ST_BT;
                        end
                        OP_BMOVE: begin
                            d.saved_fetch_ctr = q.fetch_addr_ctr;
                            d.fetch_addr_ctr = instr.ptr_long ? instr.target : q.block_addr_reg;
                            d.pc = q.pc + (instr.ptr_long ? PC_STEP_LONG : PC_STEP_SHORT);
                            d.int_hold = instr.repeat_prefix;
                            d.st = ST_BMR;
                        end
                        default: d.pc = q.pc + {14'h0000, instr.words};
                    endcase
                end
            end
            ST_BR: begin
                if (q.spec) begin
                    d.fetch.req = 1'b1;
                    d.fetch.addr = q.fetch.addr + PC_STEP_SHORT;
                    d.spec = 1'b0;
                end
                if (q.cnt != 3'h0) begin
                    d.cnt = q.cnt - 3'h1;
                end else begin
                    d.st = ST_IDLE;
                    if (q.ins.op == OP_BRD) begin
                        // Transfer waits for the two delay-slot words
                        d.pend = 1'b1;
                        d.pend_taken = q.taken;
                        d.pend_tgt = q.ins.target;
                        d.dcnt = 2'h0;
                        d.pc = q.pc + PC_STEP_BR;
                    end else if (q.taken) begin
                        d.pc = q.ins.target;
                        d.fetch.discard = 1'b1;
                    end else begin
                        d.pc = q.pc + PC_STEP_BR;
                    end
                end
            end
            ST_BT: begin
                if (q.rd_seen) begin
                    d.tc = bbbe_pick_bit(dm_rdata, (q.ins.op == OP_BITI) ? q.ins.bit_code
                        : q.temp_reg_two[3:0]);
                    d.pc = q.pc + PC_STEP_SHORT;
                    d.st = ST_IDLE;
                end
            end
            ST_BMR: begin
                // One read per cycle; the fetch counter is the pointer side
                d.dm.rd = 1'b1;
                d.dm.raddr = q.ins.ptr_src ? q.fetch_addr_ctr : q.ins.dma;
                d.dst_q1 = q.ins.ptr_src ? q.ins.dma : q.fetch_addr_ctr;
                if (q.ins.repeat_prefix && q.repeat_count_reg != 16'h0000) begin
                    d.repeat_count_reg = q.repeat_count_reg - 16'h0001;
                    d.fetch_addr_ctr = q.fetch_addr_ctr + PC_STEP_SHORT;
                end else begin
                    d.st = ST_BMD;
                end
            end
            ST_BMD: begin
                if (!q.dm.rd && !q.rd_seen) begin
                    d.fetch_addr_ctr = q.saved_fetch_ctr;
                    d.int_hold = 1'b0;
                    d.st = ST_IDLE;
                end
            end
            default: d.st = ST_IDLE;
        endcase
        d.ready = (d.st == ST_IDLE) && !(d.pend && d.dcnt >= DELAY_WORDS);
    end

    // State register; clock enable freezes everything
    always_ff @(posedge clock) begin
        if (!rst_n) begin
            q <= '0;
            q.ov <= OV_RST;
            q.tc <= TC_RST;
            q.carry <= C_RST;
            q.temp_broadcast_mode <= TRM_RST;
        end else if (ce) begin
            q <= d;
        end
    end

    // Checks below assume ce is held high
    a_br_taken_pc: assert property (@(posedge clock) disable iff (!rst_n)
        (fire && instr.op == OP_BR && taken_c) |-> ##4 (q.pc == $past(instr.target, 4) && q.ready))
        else $error("taken branch did not reach target in four cycles");
    a_br_fall_pc: assert property (@(posedge clock) disable iff (!rst_n)
        (fire && instr.op == OP_BR && !taken_c) |-> ##2 (q.pc == $past(q.pc, 2) + PC_STEP_BR))
        else $error("untaken branch did not advance by two in two cycles");
    a_cond_carry_and: assert property (@(posedge clock) disable iff (!rst_n)
        (fire && instr.op == OP_BR && instr.cond.c_tst && q.carry != instr.cond.c_val)
        |-> !taken_c ##2 q.pc == $past(q.pc, 2) + PC_STEP_BR)
        else $error("branch taken with a failing carry condition");
    a_brd_delay: assert property (@(posedge clock) disable iff (!rst_n)
        (fire && instr.op == OP_BRD && !q.pend) |-> ##2 (q.pend && q.dcnt == 2'h0 && q.ready))
        else $error("delayed branch did not open its delay slots");
    a_spec_fetch: assert property (@(posedge clock) disable iff (!rst_n)
        (fire && instr.op == OP_BR) |=> (fetch.req && fetch.addr == $past(q.pc) + PC_STEP_BR)
        ##1 (fetch.req && fetch.addr == $past(q.pc, 2) + PC_STEP_LONG + PC_STEP_SHORT))
        else $error("speculative fetch of two words missing");
    a_bit_imm_tc: assert property (@(posedge clock) disable iff (!rst_n)
        (q.st == ST_BT && q.rd_seen && q.ins.op == OP_BITI)
        |=> q.tc == $past(dm_rdata[4'hf - q.ins.bit_code]))
        else $error("immediate bit test stored the wrong bit");
    a_bit_reg_tc: assert property (@(posedge clock) disable iff (!rst_n)
        (q.st == ST_BT && q.rd_seen && q.ins.op == OP_BITR)
        |=> (q.tc == $past(dm_rdata[4'hf - q.temp_reg_two[3:0]]) && q.pc == $past(q.pc) + 16'h0001))
        else $error("register bit test stored the wrong bit");
    a_treg_bcast: assert property (@(posedge clock) disable iff (!rst_n)
        (reg_wr && reg_addr == REG_TEMP_REG_ZERO && !q.temp_broadcast_mode)
        |=> (q.temp_reg_one == $past(reg_wdata) && q.temp_reg_two == $past(reg_wdata)))
        else $error("temp zero load was not broadcast");
    a_bm_ptr_step: assert property (@(posedge clock) disable iff (!rst_n)
        (q.st == ST_BMR && q.ins.repeat_prefix && q.repeat_count_reg != 16'h0000)
        |=> (q.dm.rd && q.fetch_addr_ctr == $past(q.fetch_addr_ctr) + 16'h0001 && q.repeat_count_reg == $past(q.repeat_count_reg) - 16'h0001))
        else $error("repeated move pointer did not step once per word");
    a_bm_hold: assert property (@(posedge clock) disable iff (!rst_n)
        ((q.st == ST_BMR || q.st == ST_BMD) && q.ins.repeat_prefix) |-> int_hold)
        else $error("interrupts not held during repeated move");
    a_bm_restore: assert property (@(posedge clock) disable iff (!rst_n)
        (q.st == ST_BMD && !q.dm.rd && !q.rd_seen) |=> (q.fetch_addr_ctr == $past(q.saved_fetch_ctr) && !int_hold))
        else $error("fetch counter not restored after block move");
    a_br_discard: assert property (@(posedge clock) disable iff (!rst_n)
        (fire && instr.op == OP_BR && taken_c) |-> ##4 (fetch.discard && !fetch.req))
        else $error("speculative words not dropped on a taken branch");
    a_bit_imm_pc: assert property (@(posedge clock) disable iff (!rst_n)
        (fire && instr.op == OP_BITI) |-> ##3 (q.pc == $past(q.pc, 3) + PC_STEP_SHORT && q.ready))
        else $error("immediate bit test did not advance by one");
    a_bm_save_ctr: assert property (@(posedge clock) disable iff (!rst_n)
        (fire && instr.op == OP_BMOVE) |=> (q.saved_fetch_ctr == $past(q.fetch_addr_ctr) && int_hold == $past(instr.repeat_prefix)))
        else $error("fetch counter not saved at block move start");
    a_bm_word_cnt: assert property (@(posedge clock) disable iff (!rst_n)
        (fire && instr.op == OP_BMOVE)
        |=> (q.pc == $past(q.pc) + ($past(instr.ptr_long) ? PC_STEP_LONG : PC_STEP_SHORT)))
        else $error("block move did not step the counter by its word count");
endmodule : bbbe_exec

// *** include/bbbe_pkg.sv ***
package bbbe_pkg;
    // Register indices on the plain register port
    localparam logic [3:0] REG_ST0 = 4'h0;
    localparam logic [3:0] REG_ST1 = 4'h1;
    localparam logic [3:0] REG_PMODE = 4'h2;
    localparam logic [3:0] REG_TEMP_REG_ZERO = 4'h3;
    localparam logic [3:0] REG_TEMP_REG_ONE = 4'h4;
    localparam logic [3:0] REG_TEMP_REG_TWO = 4'h5;
    localparam logic [3:0] REG_BLOCK_ADDR_REG = 4'h6;
    localparam logic [3:0] REG_REPEAT_COUNT_REG = 4'h7;
    localparam logic [3:0] REG_PC = 4'h8;
    localparam logic [3:0] REG_PFC = 4'h9;
    localparam logic [3:0] REG_MCS = 4'ha;
    // Field positions and reset values of flag bits
    localparam int ST0_OV_BIT = 0;
    localparam int ST1_TC_BIT = 0;
    localparam int ST1_C_BIT = 1;
    localparam int PMODE_TRM_BIT = 0;
    localparam logic OV_RST = 1'b0;
    localparam logic TC_RST = 1'b0;
    localparam logic C_RST = 1'b0;
    localparam logic TRM_RST = 1'b0;
    // Timing in clock cycles, counting the accept cycle
    localparam logic [2:0] BR_TAKEN_CYC = 3'h4;
    localparam logic [2:0] BR_FALL_CYC = 3'h2;
    localparam logic [2:0] BRD_CYC = 3'h2;
    // Program counter steps and delay-slot size
    localparam logic [15:0] PC_STEP_BR = 16'h0002;
    localparam logic [15:0] PC_STEP_LONG = 16'h0002;
    localparam logic [15:0] PC_STEP_SHORT = 16'h0001;
    localparam logic [1:0] DELAY_WORDS = 2'h2;
    localparam logic [3:0] BIT_MSB = 4'hf;

    typedef enum logic [2:0] {
        OP_OTHER = 3'b000, OP_BR = 3'b001, OP_BRD = 3'b010,
        OP_BITI = 3'b011, OP_BITR = 3'b100, OP_BMOVE = 3'b101
    } bbbe_op_t;
    typedef enum logic [2:0] {
        AC_NONE = 3'b000, AC_ZERO = 3'b001, AC_NZERO = 3'b010, AC_NEG = 3'b011,
        AC_NONPOS = 3'b100, AC_POS = 3'b101, AC_NONNEG = 3'b110
    } bbbe_acc_t;
    // Pin test and test-flag test share one field, so they cannot combine
    typedef enum logic [1:0] {
        TP_NONE = 2'b00, TP_PIN_LOW = 2'b01, TP_TC_CLR = 2'b10, TP_TC_SET = 2'b11
    } bbbe_tp_t;
    typedef struct packed {
        bbbe_acc_t acc;
        logic c_tst;
        logic c_val;
        logic ov_tst;
        logic ov_val;
        bbbe_tp_t tp;
    } bbbe_cond_t;
    typedef struct packed {
        bbbe_op_t op;
        bbbe_cond_t cond;
        logic [15:0] target;
        logic [3:0] bit_code;
        logic [15:0] dma;
        logic ptr_long;
        logic ptr_src;
        logic repeat_prefix;
        logic [1:0] words;
    } bbbe_instr_t;
    typedef struct packed {
        logic req;
        logic [15:0] addr;
        logic discard;
    } bbbe_fetch_t;
    typedef struct packed {
        logic rd;
        logic [15:0] raddr;
        logic wr;
        logic [15:0] waddr;
        logic [15:0] wdata;
    } bbbe_dmem_t;
endpackage : bbbe_pkg

// *** hdl/bbbe_cond_eval.sv ***
`timescale 1ns/10ps
module bbbe_cond_eval
    import bbbe_pkg::*;
#(
    parameter int ACC_W = 32
) (
    input wire bbbe_cond_t cond,
    input wire logic [ACC_W-1:0] acc,
    input wire logic carry,
    input wire logic ov,
    input wire logic tc,
    input wire logic pin,
    output logic taken
);
    logic zero;
    logic neg;
    logic acc_ok;
    logic tp_ok;

    // Every listed condition must hold; an empty list is unconditional
    always_comb begin
        zero = (acc == '0);
        neg = acc[ACC_W-1];
        case (cond.acc)
            AC_NONE: acc_ok = 1'b1;
            AC_ZERO: acc_ok = zero;
            AC_NZERO: acc_ok = !zero;
            AC_NEG: acc_ok = neg;
            AC_NONPOS: acc_ok = neg || zero;
            AC_POS: acc_ok = !neg && !zero;
            AC_NONNEG: acc_ok = !neg;
            default: acc_ok = 1'b0;
        endcase
        case (cond.tp)
            TP_NONE: tp_ok = 1'b1;
            TP_PIN_LOW: tp_ok = !pin;
            TP_TC_CLR: tp_ok = !tc;
            TP_TC_SET: tp_ok = tc;
            default: tp_ok = 1'b0;
        endcase
        taken = acc_ok && tp_ok && (!cond.c_tst || (carry == cond.c_val))
            && (!cond.ov_tst || (ov == cond.ov_val));
    end
endmodule : bbbe_cond_eval

// *** dv/bbbe_mem_model.sv ***
`timescale 1ns/10ps
module bbbe_mem_model
    import bbbe_pkg::*;
(
    input wire logic clock,
    input wire bbbe_dmem_t dm_req,
    output logic [15:0] dm_rdata
);
    logic [15:0] mem [0:65535];

    // Cleared memory so untouched words compare as zero
    initial begin
        dm_rdata = 16'h0000;
        for (int i = 0; i < 65536; i++) begin
            mem[i] = 16'h0000;
        end
    end

    // Read data stand one cycle; after that the bus toggles so stale data never looks valid
    always @(posedge clock) begin
        if (dm_req.wr) begin
            mem[dm_req.waddr] <= dm_req.wdata;
        end
        if (dm_req.rd) begin
            dm_rdata <= mem[dm_req.raddr];
        end else begin
            dm_rdata <= ~dm_rdata;
        end
    end
endmodule : bbbe_mem_model

// *** dv/branch_bittest_blockmove_exec_test.sv ***
`timescale 1ns/10ps
module branch_bittest_blockmove_exec_test
    import bbbe_pkg::*;
;
    logic clock = 1'b0;
    logic rst_n = 1'b0;
    logic ce = 1'b1;
    logic [3:0] reg_addr = 4'h0;
    logic [15:0] reg_wdata = 16'h0000;
    logic reg_wr = 1'b0;
    logic reg_rd = 1'b0;
    logic [15:0] reg_rdata;
    logic instr_valid = 1'b0;
    bbbe_instr_t instr = '0;
    logic instr_ready;
    logic [31:0] acc = 32'h0;
    logic ext_pin_input = 1'b1;
    logic [15:0] dm_rdata;
    bbbe_dmem_t dm_req;
    bbbe_fetch_t fetch;
    logic [15:0] pc_out;
    logic int_hold;
    int fails = 0;
    int checked = 0;
    int cycles = 0;
    int hold_cnt = 0;
    int seed = 31;

    always #5 clock = ~clock;

    bbbe_exec uut (.clock(clock), .rst_n(rst_n), .ce(ce), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
        .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .instr_valid(instr_valid), .instr(instr),
        .instr_ready(instr_ready), .acc(acc), .ext_pin_input(ext_pin_input), .dm_rdata(dm_rdata),
        .dm_req(dm_req), .fetch(fetch), .pc_out(pc_out), .int_hold(int_hold));

    bbbe_mem_model partner (.clock(clock), .dm_req(dm_req), .dm_rdata(dm_rdata));

    task close_out;
        $display("checked %0d fails %0d", checked, fails);
        if (fails == 0 && checked > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask : close_out

    // Cut a hang short; the whole run needs well under this
    always @(posedge clock) begin
        cycles++;
        if (int_hold === 1'b1) begin
            hold_cnt++;
        end
        if (cycles == 20000) begin
            fails++;
            close_out;
        end
    end

    task chk(input string name, input logic [31:0] seen, input logic [31:0] exp);
        checked++;
        if (seen !== exp) begin
            fails++;
            $display("wrong value %s expected %h seen %h", name, exp, seen);
        end
    endtask : chk

    // Each access leaves a spare edge so a strobe is never set twice in one step
    task wr(input logic [3:0] a, input logic [15:0] d);
        reg_addr <= a;
        reg_wdata <= d;
        reg_wr <= 1'b1;
        @(posedge clock);
        reg_wr <= 1'b0;
        @(posedge clock);
    endtask : wr

    task rd(input logic [3:0] a, output logic [15:0] d);
        reg_addr <= a;
        reg_rd <= 1'b1;
        @(posedge clock);
        reg_rd <= 1'b0;
        @(posedge clock);
        d = reg_rdata;
    endtask : rd

    // Offer one instruction, then count cycles until ready comes back
    task run(input bbbe_instr_t i, output int cyc);
        instr <= i;
        instr_valid <= 1'b1;
        cyc = 0;
        @(posedge clock);
        while (instr_ready !== 1'b1) @(posedge clock);
        instr_valid <= 1'b0;
        do begin
            @(posedge clock);
            cyc++;
        end while (instr_ready !== 1'b1 && cyc < 100);
    endtask : run

    function automatic logic exp_taken(bbbe_cond_t c, logic [31:0] a, logic cy, logic ov, logic tc, logic pin);
        logic t;
        t = 1'b1;
        case (c.acc)
            AC_ZERO: t &= (a == 32'h0);
            AC_NZERO: t &= (a != 32'h0);
            AC_NEG: t &= ($signed(a) < 0);
            AC_NONPOS: t &= ($signed(a) <= 0);
            AC_POS: t &= ($signed(a) > 0);
            AC_NONNEG: t &= ($signed(a) >= 0);
            default: t &= 1'b1;
        endcase
        if (c.c_tst) t &= (cy == c.c_val);
        if (c.ov_tst) t &= (ov == c.ov_val);
        case (c.tp)
            TP_PIN_LOW: t &= !pin;
            TP_TC_CLR: t &= !tc;
            TP_TC_SET: t &= tc;
            default: t &= 1'b1;
        endcase
        return t;
    endfunction : exp_taken

    initial begin
        logic [15:0] v, p, d, q;
        logic ov, cy, tc, b;
        int cyc;
        bbbe_instr_t i;
        repeat (20) @(posedge clock);
        rst_n <= 1'b1;
        repeat (2) @(posedge clock);
        // Reset values, a read-only place and an unmapped index
        rd(REG_ST0, v); chk("st0", v, {15'h0, OV_RST});
        rd(REG_ST1, v); chk("st1", v, {14'h0, C_RST, TC_RST});
        rd(REG_PMODE, v); chk("pmode", v, {15'h0, TRM_RST});
        wr(REG_PC, 16'h1234); rd(REG_PC, v); chk("pc", v, 16'h0000);
        rd(4'hb, v); chk("unmapped", v, 16'h0000);
        // Broadcast on, then off
        wr(REG_TEMP_REG_ZERO, 16'h5a3c); rd(REG_TEMP_REG_ONE, v); chk("temp_reg_one", v, 16'h5a3c);
        rd(REG_TEMP_REG_TWO, v); chk("temp_reg_two", v, 16'h5a3c);
        wr(REG_PMODE, 16'h0001); wr(REG_TEMP_REG_ZERO, 16'h0f0f);
        rd(REG_TEMP_REG_TWO, v); chk("temp_reg_two kept", v, 16'h5a3c);
        $display("test registers done");
        // Random plain branches; pin and test flag share one field by construction
        for (int n = 0; n < 40; n++) begin
            ov = $random(seed); cy = $random(seed); tc = $random(seed);
            wr(REG_ST0, {15'h0, ov}); wr(REG_ST1, {14'h0, cy, tc});
            i = '0; i.op = OP_BR; i.words = 2'h2; i.target = $random(seed);
            i.cond.acc = bbbe_acc_t'(3'($unsigned($random(seed)) % 7));
            i.cond.c_tst = $random(seed); i.cond.c_val = $random(seed);
            i.cond.ov_tst = $random(seed); i.cond.ov_val = $random(seed);
            i.cond.tp = bbbe_tp_t'(2'($random(seed)));
            acc <= (n % 3 == 0) ? 32'h0 : $random(seed);
            ext_pin_input <= $random(seed);
            p = pc_out;
            run(i, cyc);
            if (exp_taken(i.cond, acc, cy, ov, tc, ext_pin_input)) begin
                chk("br pc", pc_out, i.target);
                chk("br cyc", cyc, BR_TAKEN_CYC);
                chk("br discard", fetch.discard, 1'b1);
            end else begin
                chk("br pc", pc_out, 16'(p + PC_STEP_BR));
                chk("br cyc", cyc, BR_FALL_CYC);
                chk("br discard", fetch.discard, 1'b0);
            end
            chk("spec addr", fetch.addr, 16'(p + 16'h0003));
        end
        $display("test branch done");
        // Delayed branch on overflow; the flag flips inside the delay slots
        for (int k = 0; k < 2; k++) begin
            b = k[0];
            wr(REG_ST0, {15'h0, b});
            i = '0; i.op = OP_BRD; i.words = 2'h2; i.target = 16'h0700;
            i.cond.ov_tst = 1'b1; i.cond.ov_val = 1'b1;
            p = pc_out;
            run(i, cyc); chk("brd cyc", cyc, BRD_CYC);
            wr(REG_ST0, {15'h0, ~b});
            i = '0; i.op = OP_OTHER; i.words = 2'h1;
            run(i, cyc); run(i, cyc);
            chk("brd pc", pc_out, b ? 16'h0700 : 16'(p + 16'h0004));
        end
        $display("test delayed done");
        // Every immediate bit code, then codes from temp register two
        for (int c = 0; c < 20; c++) begin
            d = $random(seed); partner.mem[16'h0080 + c] = d;
            i = '0; i.words = 2'h1; i.dma = 16'h0080 + 16'(c);
            if (c < 16) begin
                i.op = OP_BITI; i.bit_code = 4'(c); q = 16'(c);
            end else begin
                q = $random(seed); wr(REG_TEMP_REG_TWO, q); i.op = OP_BITR;
            end
            p = pc_out;
            run(i, cyc);
            rd(REG_ST1, v);
            chk("tc", v[0], d[15 - q[3:0]]);
            chk("bit pc", pc_out, 16'(p + PC_STEP_SHORT));
        end
        $display("test bit done");
        // Repeated move of four words, long pointer as destination, direct source
        // Pointers aim at plain data memory, never the mapped registers
        v = $random(seed); partner.mem[16'h0060] = v;
        wr(REG_REPEAT_COUNT_REG, 16'h0003); rd(REG_PFC, q);
        p = pc_out; hold_cnt = 0;
        i = '0; i.op = OP_BMOVE; i.words = 2'h2; i.target = 16'h0400; i.dma = 16'h0060;
        i.ptr_long = 1'b1; i.repeat_prefix = 1'b1;
        run(i, cyc);
        // Four reads back to back, two-cycle write lag, then the drain and restore cycles
        chk("move cyc", cyc, 8);
        chk("move pc", pc_out, 16'(p + PC_STEP_LONG));
        chk("hold", hold_cnt >= 4, 1);
        rd(REG_PFC, d); chk("pfc back", d, q);
        for (int k = 0; k < 4; k++) begin
            chk("moved", partner.mem[16'h0400 + k], v);
        end
        chk("past end", partner.mem[16'h0404], 16'h0000);
        // Single move, block register as source
        wr(REG_BLOCK_ADDR_REG, 16'h0500); d = $random(seed); partner.mem[16'h0500] = d;
        i = '0; i.op = OP_BMOVE; i.words = 2'h1; i.dma = 16'h0070; i.ptr_src = 1'b1;
        p = pc_out;
        run(i, cyc);
        chk("move1 cyc", cyc, 5);
        chk("move1 pc", pc_out, 16'(p + PC_STEP_SHORT));
        repeat (3) @(posedge clock);
        chk("move1", partner.mem[16'h0070], d);
        $display("test move done");
        close_out;
    end
endmodule : branch_bittest_blockmove_exec_test
